/* File: rtl/cpf_pkg.sv */
// Shared constants and types of the core sequencer.
package cpf_pkg;
  // ************************************************************
  // Address widths and spaces
  // ************************************************************
  localparam int          PC_W         = 13;
  localparam int          DATA_W       = 8;
  localparam int          RAM_AW       = 8;
  localparam int          RAM_BYTES    = 256;
  localparam int          IN_REG_CNT   = 20;
  localparam int          OUT_REG_CNT  = 6;
  localparam int          CONF_REG_CNT = 21;
  localparam int          PROG_BYTES   = 8192;
  localparam int          FSTK_DEPTH   = 8;
  localparam int          DEPTH_W      = 4;
  localparam int          STK_STEP     = 2;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [7:0]  IR_SP_ADDR   = 8'h00;
  // ************************************************************
  // Instruction classes and sub-operations
  // ************************************************************
  localparam int          NBLK         = 5;
  typedef enum logic [2:0] {
    CLS_LOAD = 3'h0, CLS_ARITH = 3'h1, CLS_JUMP = 3'h2, CLS_CTRL = 3'h3, CLS_DP = 3'h4
  } cpf_cls_t;
  typedef enum logic [1:0] {
    OP_JUMP = 2'h0, OP_CALL = 2'h1, OP_RET = 2'h2, OP_INTERRUPT_EXIT = 2'h3
  } cpf_jop_t;
  typedef enum logic [1:0] {
    OP_ADD = 2'h0, OP_SUB = 2'h1, OP_AND = 2'h2, OP_OR = 2'h3
  } cpf_aop_t;
  // ************************************************************
  // Sequencer states
  // ************************************************************
  typedef enum logic [6:0] {
    ST_RUN   = 7'h01, ST_PUSH = 7'h02, ST_POPA = 7'h04, ST_POPB = 7'h08,
    ST_POPC  = 7'h10, ST_ARRD = 7'h20, ST_ARWB = 7'h40
  } cpf_state_t;
  // ************************************************************
  // APB register map
  // ************************************************************
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_STATUS   = 12'h004;
  localparam logic [11:0] REG_STACK    = 12'h008;
  localparam int          CTRL_RUN_BIT = 0;
  localparam logic        CTRL_RUN_RST = 1'b1;
  localparam int          ST_PC_LSB    = 0;
  localparam int          ST_FLG_LSB   = 16;
  localparam int          ST_IRQ_BIT   = 19;
  localparam int          ST_DEP_LSB   = 24;
endpackage : cpf_pkg

/* File: rtl/cpf_ram.sv */
// Data RAM with a single port and registered read data.
`timescale 1ns/1ps
`default_nettype none
module cpf_ram #(
  parameter int AW    = 8,
  parameter int DW    = 8,
  parameter int BYTES = 256
) (
  // Clock
  input  wire logic          core_clk,
  // Access port
  input  wire logic [AW-1:0] addr,
  input  wire logic          wrEn,
  input  wire logic [DW-1:0] wrData,
  output logic      [DW-1:0] rdData
);
  logic [DW-1:0] mem [BYTES];

  // No reset on the array: contents are undefined until written
  always_ff @(posedge core_clk)
  begin
    if (wrEn)
    begin
      mem[addr] <= wrData;
    end
    rdData <= mem[addr];
  end
endmodule : cpf_ram
`default_nettype wire

/* File: rtl/cpf_core.sv */
// Program counter, banked flags, flag stack, RAM stack and decode arbitration.
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Keeps a 13-bit program counter addressing the next program location.
// - Jump and call targets are absolute 13-bit addresses over 8192 bytes.
// - Next PC is jump target, vector, popped value, reset vector or PC+1.
// - Two flag banks, normal and interrupt, seen as one logical set.
// - After an interrupt is taken, flags use the interrupt bank.
// - Each nesting level's flags are saved on a flag stack when preempted.
// - Interrupt exit restores previous flags; normal flags when leaving to normal.
// - Call and subroutine exit never switch banks or touch normal flags.
// - Banks are never cleared on context switches.
// - Arithmetic sets carry on overflow, clears it otherwise; AND and OR keep it.
// - Arithmetic sets sign on underflow, clears it otherwise; AND and OR keep it.
// - Data RAM of 128 or 256 bytes from address zero, reached by loads.
// - Call or interrupt pushes PC into RAM, two bytes, from top address.
// - A push moves levels deeper and places PC in the first level.
// - A return loads PC from the first level, levels move back up.
// - Separate spaces: RAM, 20 input, 6 output, 21 config registers, program.
// - Decoding splits into load, arithmetic, jump, control and decision blocks.
// - An arbiter activates exactly one block per fetched instruction.
// - Arithmetic operates directly on any RAM address.
// - General reset reinitialises registers and restarts at the reset vector.
// - Input register zero reads the current stack pointer.
module cpf_core
  import cpf_pkg::*;
#(
  parameter int RAM_SIZE = cpf_pkg::RAM_BYTES
) (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Fetched instruction
  input  wire logic                    instrValid,
  input  wire cpf_pkg::cpf_cls_t       instrClass,
  input  wire logic [1:0]              instrOp,
  input  wire logic [cpf_pkg::PC_W-1:0] instrTarget,
  input  wire logic [7:0]              instrRamAddr,
  input  wire logic [7:0]              instrData,
  output logic                         instrReady,
  // Interrupt request
  input  wire logic                    irqReq,
  input  wire logic [cpf_pkg::PC_W-1:0] irqVector,
  output logic                         irqAck,
  // Input register read port
  input  wire logic [7:0]              inRegAddr,
  input  wire logic [7:0]              inRegExt,
  output logic      [7:0]              inRegData,
  // Sequencer state
  output logic      [cpf_pkg::PC_W-1:0] programCounter,
  output logic      [2:0]              flagsCZS,
  output logic                         irqMode,
  output logic      [cpf_pkg::NBLK-1:0] blkSel
);
  import cpf_pkg::*;

  localparam logic [7:0] SP_TOP = 8'(RAM_SIZE - 1);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    cpf_state_t                       st;
    logic [PC_W-1:0]                  pc;
    logic [7:0]                       sp;
    logic [2:0]                       normFlg;
    logic [2:0]                       irqFlg;
    logic [DEPTH_W-1:0]               depth;
    logic [FSTK_DEPTH-1:0][2:0]       flagStk;
    logic                             popIsReti;
    logic [4:0]                       popHi;
    logic [7:0]                       opAddr;
    logic [7:0]                       opData;
    logic [1:0]                       opSub;
    logic                             runEn;
    logic [31:0]                      rdData;
    logic                             slvErr;
    logic [NBLK-1:0]                  blk;
    logic [7:0]                       inReg;
    logic                             ack;
  } cpf_core_t;

  cpf_core_t cur_ff;
  cpf_core_t nxt_ff;

  logic [7:0] ramAddr;
  logic       ramWe;
  logic [7:0] ramWData;
  logic [7:0] ramRData;

  cpf_ram #(
    .AW    (RAM_AW),
    .DW    (DATA_W),
    .BYTES (RAM_SIZE)
  ) uRam (
    .core_clk (core_clk),
    .addr     (ramAddr),
    .wrEn     (ramWe),
    .wrData   (ramWData),
    .rdData   (ramRData)
  );

  // ************************************************************
  // Next-state logic
  // ************************************************************
  logic [8:0]  aluSum;
  logic [8:0]  aluDif;
  logic [7:0]  aluRes;
  logic [2:0]  aluFlg;
  logic [2:0]  actFlg;
  logic        canRun;
  logic        apbSetup;
  logic [31:0] statusWord;

  always_comb
  begin
    nxt_ff   = cur_ff;
    ramAddr  = cur_ff.sp;
    ramWe    = 1'b0;
    ramWData = 8'h00;
    nxt_ff.ack = 1'b0;
    canRun   = (cur_ff.st == ST_RUN) && cur_ff.runEn;
    actFlg   = (cur_ff.depth != '0) ? cur_ff.irqFlg : cur_ff.normFlg;
    // ALU on a RAM operand; flags are {carry, zero, sign}
    aluSum   = {1'b0, ramRData} + {1'b0, cur_ff.opData};
    aluDif   = {1'b0, ramRData} - {1'b0, cur_ff.opData};
    aluRes   = 8'h00;
    aluFlg   = actFlg;
    case (cur_ff.opSub)
      OP_ADD:
      begin
        aluRes = aluSum[7:0];
        aluFlg = {aluSum[8], aluSum[7:0] == 8'h00, 1'b0};
      end
      OP_SUB:
      begin
        aluRes = aluDif[7:0];
        aluFlg = {1'b0, aluDif[7:0] == 8'h00, aluDif[8]};
      end
      OP_AND:
      begin
        aluRes = ramRData & cur_ff.opData;
        aluFlg = {actFlg[2], aluRes == 8'h00, actFlg[0]};
      end
      default:
      begin
        aluRes = ramRData | cur_ff.opData;
        aluFlg = {actFlg[2], aluRes == 8'h00, actFlg[0]};
      end
    endcase

    case (cur_ff.st)
      ST_RUN:
      begin
        nxt_ff.blk = '0;
        if (cur_ff.runEn && irqReq)
        begin
          // Interrupt wins over a waiting instruction; PC is pushed first
          nxt_ff.ack = 1'b1;
          ramWe      = 1'b1;
          ramWData   = cur_ff.pc[7:0];
          if (cur_ff.depth != '0)
          begin
            nxt_ff.flagStk[cur_ff.depth - DEPTH_W'(1)] = cur_ff.irqFlg;
          end
          nxt_ff.depth = cur_ff.depth + DEPTH_W'(1);
          nxt_ff.popHi = cur_ff.pc[12:8];
          nxt_ff.pc    = irqVector;
          nxt_ff.st    = ST_PUSH;
        end
        else if (canRun && instrValid)
        begin
          nxt_ff.pc = cur_ff.pc + PC_W'(1);
          nxt_ff.blk[instrClass] = 1'b1;
          case (instrClass)
            CLS_LOAD:
            begin
              ramAddr  = instrRamAddr;
              ramWe    = 1'b1;
              ramWData = instrData;
            end
            CLS_ARITH:
            begin
              ramAddr       = instrRamAddr;
              nxt_ff.opAddr = instrRamAddr;
              nxt_ff.opData = instrData;
              nxt_ff.opSub  = instrOp;
              nxt_ff.st     = ST_ARRD;
            end
            CLS_JUMP:
            begin
              case (instrOp)
                OP_JUMP:
                begin
                  nxt_ff.pc = instrTarget;
                end
                OP_CALL:
                begin
                  // Return address is the location after the call; flags untouched
                  ramWe        = 1'b1;
                  ramWData     = nxt_ff.pc[7:0];
                  nxt_ff.popHi = nxt_ff.pc[12:8];
                  nxt_ff.pc    = instrTarget;
                  nxt_ff.st    = ST_PUSH;
                end
                default:
                begin
                  nxt_ff.popIsReti = (instrOp == OP_INTERRUPT_EXIT);
                  nxt_ff.st        = ST_POPA;
                end
              endcase
            end
            default:
            begin
              nxt_ff.st = ST_RUN;
            end
          endcase
        end
      end
      ST_PUSH:
      begin
        ramAddr   = cur_ff.sp - 8'h01;
        ramWe     = 1'b1;
        ramWData  = {3'h0, cur_ff.popHi};
        nxt_ff.sp = cur_ff.sp - 8'(STK_STEP);
        nxt_ff.st = ST_RUN;
      end
      ST_POPA:
      begin
        ramAddr   = cur_ff.sp + 8'h01;
        nxt_ff.st = ST_POPB;
      end
      ST_POPB:
      begin
        ramAddr      = cur_ff.sp + 8'(STK_STEP);
        nxt_ff.popHi = ramRData[4:0];
        nxt_ff.st    = ST_POPC;
      end
      ST_POPC:
      begin
        nxt_ff.pc = {cur_ff.popHi, ramRData};
        nxt_ff.sp = cur_ff.sp + 8'(STK_STEP);
        if (cur_ff.popIsReti && (cur_ff.depth != '0))
        begin
          nxt_ff.depth = cur_ff.depth - DEPTH_W'(1);
          if (cur_ff.depth > DEPTH_W'(1))
          begin
            nxt_ff.irqFlg = cur_ff.flagStk[cur_ff.depth - DEPTH_W'(2)];
          end
        end
        nxt_ff.popIsReti = 1'b0;
        nxt_ff.st        = ST_RUN;
      end
      ST_ARRD:
      begin
        ramAddr   = cur_ff.opAddr;
        nxt_ff.st = ST_ARWB;
      end
      ST_ARWB:
      begin
        ramAddr  = cur_ff.opAddr;
        ramWe    = 1'b1;
        ramWData = aluRes;
        if (cur_ff.depth != '0)
        begin
          nxt_ff.irqFlg = aluFlg;
        end
        else
        begin
          nxt_ff.normFlg = aluFlg;
        end
        nxt_ff.st = ST_RUN;
      end
      default:
      begin
        nxt_ff.st = ST_RUN;
      end
    endcase

    // Input register space: index zero is the stack pointer
    if (inRegAddr == IR_SP_ADDR)
    begin
      nxt_ff.inReg = cur_ff.sp;
    end
    else if (inRegAddr < 8'(IN_REG_CNT))
    begin
      nxt_ff.inReg = inRegExt;
    end
    else
    begin
      nxt_ff.inReg = 8'h00;
    end

    // APB: data latched in the setup cycle, answered in the access cycle
    statusWord = 32'h0;
    statusWord[ST_PC_LSB +: PC_W]     = cur_ff.pc;
    statusWord[ST_FLG_LSB +: 3]       = actFlg;
    statusWord[ST_IRQ_BIT]            = (cur_ff.depth != '0);
    statusWord[ST_DEP_LSB +: DEPTH_W] = cur_ff.depth;
    apbSetup = psel && !penable;
    if (apbSetup)
    begin
      nxt_ff.slvErr = 1'b0;
      nxt_ff.rdData = 32'h0;
      case (paddr)
        REG_CTRL:
        begin
          nxt_ff.rdData[CTRL_RUN_BIT] = cur_ff.runEn;
        end
        REG_STATUS:
        begin
          nxt_ff.rdData = statusWord;
        end
        REG_STACK:
        begin
          nxt_ff.rdData[7:0] = cur_ff.sp;
        end
        default:
        begin
          nxt_ff.slvErr = 1'b1;
        end
      endcase
    end
    if (psel && penable && pwrite && (paddr == REG_CTRL))
    begin
      nxt_ff.runEn = pwdata[CTRL_RUN_BIT];
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cur_ff       <= '0;
      cur_ff.st    <= ST_RUN;
      cur_ff.pc    <= RESET_VECTOR;
      cur_ff.sp    <= SP_TOP;
      cur_ff.runEn <= CTRL_RUN_RST;
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign prdata         = cur_ff.rdData;
  assign pready         = 1'b1;
  assign pslverr        = psel && penable && cur_ff.slvErr;
  assign instrReady     = (cur_ff.st == ST_RUN) && cur_ff.runEn && !irqReq;
  assign irqAck         = cur_ff.ack;
  assign inRegData      = cur_ff.inReg;
  assign programCounter = cur_ff.pc;
  assign flagsCZS       = (cur_ff.depth != '0) ? cur_ff.irqFlg : cur_ff.normFlg;
  assign irqMode        = (cur_ff.depth != '0);
  assign blkSel         = cur_ff.blk;

  // ************************************************************
  // Checks
  // ************************************************************
  pc_incr_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (canRun && instrValid && !irqReq && instrClass == CLS_LOAD) |=> programCounter == $past(cur_ff.pc) + PC_W'(1))
    else $error("pc not incremented");
  jump_tgt_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (instrReady && instrValid && instrClass == CLS_JUMP && instrOp == OP_JUMP) |=> programCounter == $past(instrTarget))
    else $error("jump target not loaded");
  one_blk_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $onehot0(blkSel) and ((instrReady && instrValid) |=> $onehot(blkSel)))
    else $error("arbiter selected wrong block count");
  irq_mode_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    irqAck |-> irqMode && cur_ff.depth == $past(cur_ff.depth) + DEPTH_W'(1))
    else $error("irq mode not entered");
  push_sp_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (cur_ff.st == ST_PUSH) |=> cur_ff.sp == $past(cur_ff.sp) - 8'(STK_STEP))
    else $error("stack pointer push step wrong");
  call_flag_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (instrReady && instrValid && instrClass == CLS_JUMP && instrOp != OP_INTERRUPT_EXIT && instrOp != OP_JUMP)
    |=> ##3 cur_ff.normFlg == $past(cur_ff.normFlg, 4) && cur_ff.depth == $past(cur_ff.depth, 4))
    else $error("call or return touched flags");
  ret_pc_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (cur_ff.st == ST_POPC) |=> programCounter == {$past(cur_ff.popHi), $past(ramRData)}
      && cur_ff.sp == $past(cur_ff.sp) + 8'(STK_STEP))
    else $error("return did not pop pc");
  interrupt_exit_lvl_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (cur_ff.st == ST_POPC && cur_ff.popIsReti && cur_ff.depth == DEPTH_W'(1)) |=> !irqMode)
    else $error("normal flags not restored");
  carry_set_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (cur_ff.st == ST_ARWB && cur_ff.opSub == OP_ADD) |=> flagsCZS[2] == $past(aluSum[8]))
    else $error("carry flag wrong");
  sp_read_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (rst_b && inRegAddr == IR_SP_ADDR) |=> inRegData == $past(cur_ff.sp))
    else $error("input register zero is not stack pointer");
endmodule : cpf_core
`default_nettype wire

/* File: sim/cpf_prog_model.sv */
// Program memory side model: offers fetched instructions to the sequencer.
`timescale 1ns/1ps
`default_nettype none
module cpf_prog_model
  import cpf_pkg::*;
(
  // Clock
  input  wire logic                 core_clk,
  // Fetch handshake
  input  wire logic                 instrReady,
  output logic                      instrValid,
  output var cpf_pkg::cpf_cls_t     instrClass,
  output logic [1:0]                instrOp,
  output logic [cpf_pkg::PC_W-1:0]  instrTarget,
  output logic [7:0]                instrRamAddr,
  output logic [7:0]                instrData
);
  initial
  begin
    instrValid   = 1'b0;
    instrClass   = CLS_CTRL;
    instrOp      = 2'h0;
    instrTarget  = 13'h0;
    instrRamAddr = 8'h0;
    instrData    = 8'h0;
  end

  // Holds the offer until taken; idle target, RAM address and data are inverted so stale values cannot pass
  task automatic give(input cpf_cls_t c, input logic [1:0] op, input logic [12:0] t,
                      input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    instrValid   <= 1'b1;
    instrClass   <= c;
    instrOp      <= op;
    instrTarget  <= t;
    instrRamAddr <= a;
    instrData    <= d;
    do @(posedge core_clk); while (!instrReady);
    instrValid   <= 1'b0;
    instrTarget  <= ~t;
    instrRamAddr <= ~a;
    instrData    <= ~d;
  endtask : give
endmodule : cpf_prog_model
`default_nettype wire

/* File: sim/core_pc_flags_stack_bench.sv */
// Self-checking bench of the sequencer: fetch, stacks, flag banks, APB view.
`timescale 1ns/1ps
`default_nettype none
module core_pc_flags_stack_bench;
  import cpf_pkg::*;
  logic            core_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic            instrValid, instrReady, irqReq, irqAck, irqMode;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, rd;
  cpf_cls_t        instrClass;
  logic [1:0]      instrOp;
  logic [PC_W-1:0] instrTarget, irqVector, programCounter, pcExp;
  logic [7:0]      instrRamAddr, instrData, inRegAddr, inRegExt, inRegData, spExp;
  logic [2:0]      flagsCZS, flExp, flIrq;
  logic [NBLK-1:0] blkSel;
  logic [7:0]      mem [256];
  logic [PC_W-1:0] pcStk [$];
  logic [2:0]      flStk [$];
  int              n_mismatch = 0;
  int              n_checks = 0;
  int              cyc = 0;
  int              depth;

  cpf_core dut_u (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instrValid(instrValid), .instrClass(instrClass), .instrOp(instrOp), .instrTarget(instrTarget),
    .instrRamAddr(instrRamAddr), .instrData(instrData), .instrReady(instrReady), .irqReq(irqReq),
    .irqVector(irqVector), .irqAck(irqAck), .inRegAddr(inRegAddr), .inRegExt(inRegExt),
    .inRegData(inRegData), .programCounter(programCounter), .flagsCZS(flagsCZS), .irqMode(irqMode),
    .blkSel(blkSel));
  cpf_prog_model prog_u (.core_clk(core_clk), .instrReady(instrReady), .instrValid(instrValid),
    .instrClass(instrClass), .instrOp(instrOp), .instrTarget(instrTarget), .instrRamAddr(instrRamAddr),
    .instrData(instrData));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Hang guard
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      finish_test();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (!pready);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic settle();
    #1;
    while (!instrReady)
    begin
      @(posedge core_clk);
      #1;
    end
    chk(32'(programCounter), 32'(pcExp));
    chk(32'(flagsCZS), 32'(flExp));
    apb(1'b0, REG_STACK, 32'h0);
    chk(32'(rd[7:0]), 32'(spExp));
  endtask : settle

  task automatic doReset();
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    pcExp = RESET_VECTOR;
    spExp = 8'hff;
    flExp = 3'h0;
    flIrq = 3'h0;
    depth = 0;
    pcStk.delete();
    flStk.delete();
    @(posedge core_clk);
    settle();
  endtask : doReset

  task automatic exec(input cpf_cls_t c, input logic [1:0] op, input logic [12:0] t,
                      input logic [7:0] a, input logic [7:0] d);
    logic [8:0] r;
    prog_u.give(c, op, t, a, d);
    #1;
    chk(32'(blkSel), 32'(5'h1 << c));
    pcExp = pcExp + 13'h1;
    if (c == CLS_LOAD)
      mem[a] = d;
    if (c == CLS_ARITH)
    begin
      r = (op == OP_ADD) ? mem[a] + d : (op == OP_SUB) ? mem[a] - d : (op == OP_AND) ? mem[a] & d : mem[a] | d;
      flExp = op[1] ? {flExp[2], r[7:0] == 8'h0, flExp[0]} : {~op[0] & r[8], r[7:0] == 8'h0, op[0] & r[8]};
      mem[a] = r[7:0];
    end
    if (c == CLS_JUMP && op == OP_CALL)
    begin
      pcStk.push_back(pcExp);
      spExp = spExp - 8'h2;
    end
    if (c == CLS_JUMP && op[1])
    begin
      pcExp = pcStk.pop_back();
      spExp = spExp + 8'h2;
    end
    else if (c == CLS_JUMP)
      pcExp = t;
    if (c == CLS_JUMP && op == OP_INTERRUPT_EXIT)
    begin
      depth = depth - 1;
      if (depth == 0)
        flIrq = flExp;
      flExp = flStk.pop_back();
    end
    settle();
  endtask : exec

  // Loads a RAM byte, then runs one arithmetic or logic operation on it
  task automatic ar(input logic [7:0] a, input logic [7:0] x, input logic [1:0] op, input logic [7:0] d);
    exec(CLS_LOAD, 2'h0, 13'h0, a, x);
    exec(CLS_ARITH, op, 13'h0, a, d);
  endtask : ar

  task automatic irq(input logic [12:0] v);
    int k;
    @(posedge core_clk);
    irqReq    <= 1'b1;
    irqVector <= v;
    k = 0;
    do @(posedge core_clk); while (!irqAck && ++k < 50);
    chk(32'(irqAck), 32'h1);
    irqReq    <= 1'b0;
    irqVector <= ~v;
    pcStk.push_back(pcExp);
    pcExp = v;
    spExp = spExp - 8'h2;
    flStk.push_back(flExp);
    if (depth == 0)
      flExp = flIrq;
    depth = depth + 1;
    settle();
    chk(32'(irqMode), 32'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(32'(rd[27:24]), 32'(depth));
  endtask : irq

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [7:0] a;
    rst_b = 1'b0;
    {psel, penable, pwrite, irqReq} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    irqVector = 13'h0;
    inRegAddr = 8'h0;
    inRegExt = 8'h0;
    void'($urandom(2534));
    doReset();
    apb(1'b0, REG_CTRL, 32'h0);
    chk(32'({err, rd[0]}), 32'({1'b0, CTRL_RUN_RST}));
    apb(1'b0, 12'hff0, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, REG_CTRL, 32'h0);
    #1;
    chk(32'(instrReady), 32'h0);
    apb(1'b1, REG_CTRL, 32'h1);
    foreach (mem[i])
      mem[i] = 8'h0;
    for (int i = 0; i < 4; i++)
    begin
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'h05 : (i == 2) ? 8'h13 : 8'h14;
      @(posedge core_clk);
      inRegAddr <= a;
      inRegExt  <= 8'($urandom);
      @(posedge core_clk);
      #1;
      chk(32'(inRegData), 32'(a == 8'h0 ? spExp : a < 8'd20 ? inRegExt : 8'h0));
    end
    exec(CLS_CTRL, 2'h0, 13'h0, 8'h0, 8'h0);
    exec(CLS_DP, 2'h0, 13'h0, 8'h0, 8'h0);
    exec(CLS_JUMP, OP_JUMP, 13'h1ffe, 8'h0, 8'h0);
    exec(CLS_LOAD, 2'h0, 13'h0, 8'h00, 8'h5a);
    exec(CLS_JUMP, OP_JUMP, 13'($urandom), 8'h0, 8'h0);
    ar(8'h00, 8'hff, OP_ADD, 8'h01);
    ar(8'h7f, 8'h00, OP_SUB, 8'h01);
    for (int i = 0; i < 16; i++)
      ar(8'($urandom % 200), 8'($urandom), 2'($urandom), 8'($urandom));
    // Shallow nesting keeps the RAM stack far from the data area
    exec(CLS_JUMP, OP_CALL, 13'h0400, 8'h0, 8'h0);
    exec(CLS_JUMP, OP_CALL, 13'h1234, 8'h0, 8'h0);
    exec(CLS_JUMP, OP_RET, 13'h0, 8'h0, 8'h0);
    exec(CLS_JUMP, OP_RET, 13'h0, 8'h0, 8'h0);
    ar(8'h10, 8'hff, OP_ADD, 8'h01);
    irq(13'h0100);
    ar(8'h11, 8'h01, OP_SUB, 8'h02);
    irq(13'h0200);
    ar(8'h12, 8'h10, OP_ADD, 8'h10);
    exec(CLS_JUMP, OP_INTERRUPT_EXIT, 13'h0, 8'h0, 8'h0);
    exec(CLS_JUMP, OP_INTERRUPT_EXIT, 13'h0, 8'h0, 8'h0);
    chk(32'(irqMode), 32'h0);
    irq(13'h0100);
    exec(CLS_JUMP, OP_INTERRUPT_EXIT, 13'h0, 8'h0, 8'h0);
    doReset();
    finish_test();
  end
endmodule : core_pc_flags_stack_bench
`default_nettype wire
